/* File: core/pmrc_consts.vh */
`ifndef PMRC_CONSTS_VH
`define PMRC_CONSTS_VH
// clock cycles counted in the start-up state before releasing reset
`define PMRC_STARTUP_PERIODS 1024
// length of the watchdog reset pulse driven on the reset pin
`define PMRC_WDOG_PULSE_PERIODS 96
// counter widths
`define PMRC_CNT_W 11
`define PMRC_PULSE_W 7
`endif

/* File: core/pmrc_sync.v */
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for one level
module pmrc_sync (
    // clock and control
    input wire clock,
    input wire sys_rst,
    input wire clk_en,
    // level in and out
    input wire d,
    output wire q
);
    reg meta;
    reg stable;
    always @(posedge clock) begin
        if (sys_rst) begin
            meta <= 1'b0;
            stable <= 1'b0;
        end else if (clk_en) begin
            meta <= d;
            stable <= meta;
        end
    end
    assign q = stable;
endmodule // pmrc_sync
`default_nettype wire

/* File: core/pmrc_top.v */
`timescale 1ns/10ps
`default_nettype none
`include "pmrc_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Internal reset asserted at once at power-up, before any check.
// - With supply safe, hold reset until the oscillator is seen toggling.
// - Then count 1024 oscillator periods before releasing internal reset (the code counts 1024 clock cycles instead).
// - Supply-fail indication asserts internal reset at once, no counting.
// - Internal reset goes to core, memories and peripherals together.
// - Reset asserted on monitor, watchdog, array watchdog or pin request.
// - Device stays in reset as long as the external reset input is held.
// - Hardware watchdog expiry drives a 96-period pulse onto the reset pin.
module pmrc_top #(
    parameter STARTUP_PERIODS = `PMRC_STARTUP_PERIODS,
    parameter PULSE_PERIODS = `PMRC_WDOG_PULSE_PERIODS
) (
    // clock, reset and enable
    input wire clock,
    input wire sys_rst,
    input wire clk_en,
    // supply monitor and oscillator
    input wire supply_fail_detect,
    input wire oscillator_input,
    // watchdog requests
    input wire hardware_watchdog_expire,
    input wire counter_array_watchdog_expire,
    // reset pin (two-way)
    input wire reset_pin_in,
    output wire reset_pin_out,
    output wire reset_pin_oe,
    // internal reset outputs
    output reg core_reset,
    output reg memory_reset,
    output reg periph_reset,
    output reg monitor_reset
);
    ////////////////////////////////////////////////////////////////////////////
    // one-hot sequence states:
    // powerup  - supply unsafe, everything held
    // wait_osc - supply safe, waiting for both oscillator edges
    // count    - start-up delay running
    // run      - sequence done, only the request sources or a supply fail can hold reset
    localparam [3:0] ST_POWERUP = 4'h1;
    localparam [3:0] ST_WAIT_OSC = 4'h2;
    localparam [3:0] ST_COUNT = 4'h4;
    localparam [3:0] ST_RUN = 4'h8;

    reg [3:0] state;
    reg [3:0] next_state;
    reg [`PMRC_CNT_W-1:0] cnt;
    reg [`PMRC_CNT_W-1:0] next_cnt;
    reg [`PMRC_PULSE_W-1:0] pulse_cnt;
    reg osc_prev;
    reg seen_high;
    reg seen_low;
    wire pin_sync;
    wire osc_sync;
    wire pulse_active;
    wire ext_req;
    wire any_req;
    wire osc_rise;
    wire osc_fall;
    wire supply_ok;
    wire osc_toggling;
    wire count_done;
    wire seq_hold;
    wire [`PMRC_CNT_W-1:0] count_last;

    // clk_en low freezes every flop here, the synchronisers included, so a
    // frozen block neither counts nor loses a pending request

    ////////////////////////////////////////////////////////////////////////////
    // pin and oscillator synchronisers
    // both inputs come from the board and may change at any time; only the
    // second flop of each is read below
    pmrc_sync u_pin_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .d(reset_pin_in),
        .q(pin_sync)
    );
    pmrc_sync u_osc_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .d(oscillator_input),
        .q(osc_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // watchdog pulse on the reset pin; own pulse is masked only while active, so its synchronised tail is taken as external for two clocks
    // a new expiry during the pulse is ignored; the pulse is never restarted
    // so the board sees one clean pulse of fixed length
    assign pulse_active = (pulse_cnt != {`PMRC_PULSE_W{1'b0}});
    assign reset_pin_out = pulse_active;
    assign reset_pin_oe = pulse_active;
    always @(posedge clock) begin
        if (sys_rst) begin
            pulse_cnt <= {`PMRC_PULSE_W{1'b0}};
        end else if (clk_en) begin
            if (hardware_watchdog_expire && !pulse_active) begin
                pulse_cnt <= PULSE_PERIODS[`PMRC_PULSE_W-1:0];
            end else if (pulse_active) begin
                pulse_cnt <= pulse_cnt - 1'b1;
            end
        end
    end
    assign ext_req = pin_sync & ~pulse_active;
    // any one source is enough to hold the combined reset
    assign any_req = ext_req |
        hardware_watchdog_expire |
        counter_array_watchdog_expire |
        pulse_active;

    ////////////////////////////////////////////////////////////////////////////
    // oscillator edges, taken from the synchronised level only
    assign osc_rise = osc_sync & ~osc_prev;
    assign osc_fall = ~osc_sync & osc_prev;

    ////////////////////////////////////////////////////////////////////////////
    // oscillator activity: a rising and a falling edge seen in the wait state
    always @(posedge clock) begin
        if (sys_rst) begin
            osc_prev <= 1'b0;
            seen_high <= 1'b0;
            seen_low <= 1'b0;
        end else if (clk_en) begin
            osc_prev <= osc_sync;
            if (state != ST_WAIT_OSC) begin
                seen_high <= 1'b0;
                seen_low <= 1'b0;
            end else begin
                if (osc_rise) begin
                    seen_high <= 1'b1;
                end
                if (osc_fall) begin
                    seen_low <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequence conditions
    // the supply flag is used as it comes: it can only restart the sequence,
    // so a late sample costs one clock and never shortens the start-up count
    assign supply_ok = ~supply_fail_detect;
    // both edges must be seen; a stuck oscillator never leaves the wait
    assign osc_toggling = seen_high & seen_low;
    // the counter runs from zero to STARTUP_PERIODS-1, one clock each;
    // STARTUP_PERIODS must fit the counter width
    assign count_last = STARTUP_PERIODS[`PMRC_CNT_W-1:0] - 1'b1;
    assign count_done = (cnt == count_last);
    // reset held by the sequence until the counter is done
    assign seq_hold = (next_state != ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // power monitor sequence
    always @* begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            ST_POWERUP: begin
                next_cnt = {`PMRC_CNT_W{1'b0}};
                if (supply_ok) begin
                    next_state = ST_WAIT_OSC;
                end
            end
            ST_WAIT_OSC: begin
                next_cnt = {`PMRC_CNT_W{1'b0}};
                if (osc_toggling) begin
                    next_state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (count_done) begin
                    next_state = ST_RUN;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            ST_RUN: begin
                next_cnt = {`PMRC_CNT_W{1'b0}};
            end
            default: begin
                next_state = ST_POWERUP;
                next_cnt = {`PMRC_CNT_W{1'b0}};
            end
        endcase
        if (supply_fail_detect) begin
            next_state = ST_POWERUP;
            next_cnt = {`PMRC_CNT_W{1'b0}};
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            state <= ST_POWERUP;
            cnt <= {`PMRC_CNT_W{1'b0}};
        end else if (clk_en) begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // combined reset, asserted and released on the clock edge
    always @(posedge clock) begin
        if (sys_rst) begin
            monitor_reset <= 1'b1;
            core_reset <= 1'b1;
            memory_reset <= 1'b1;
            periph_reset <= 1'b1;
        end else if (clk_en) begin
            // supply sequence alone
            monitor_reset <= seq_hold;
            // sequence or any request, the same value on all three
            core_reset <= seq_hold | any_req;
            memory_reset <= seq_hold | any_req;
            periph_reset <= seq_hold | any_req;
        end
    end
endmodule // pmrc_top
`default_nettype wire

/* File: tb/pmrc_board.sv */
`timescale 1ns/10ps
`default_nettype none
module pmrc_board (
    input wire logic clock, osc_run, ext_hold, pin_out, pin_oe,
    output logic osc,
    output wire logic pin
);
    initial osc = 1'b0;
    always @(negedge clock) if (osc_run) osc <= !osc;
    // the external hold level drives the pin whenever the device does not drive it
    assign pin = pin_oe ? pin_out : ext_hold;
endmodule // pmrc_board
`default_nettype wire

/* File: tb/pmrc_top_props.sv */
`timescale 1ns/10ps
`default_nettype none
module pmrc_top_props #(parameter int PULSE_PERIODS = 96) (
    input wire logic clock, sys_rst, clk_en, supply_fail_detect,
    input wire logic oscillator_input, hardware_watchdog_expire,
    input wire logic counter_array_watchdog_expire, reset_pin_in,
    input wire logic reset_pin_out, reset_pin_oe, core_reset,
    input wire logic memory_reset, periph_reset, monitor_reset
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    int pulse_len;
    always @(posedge clock)
        pulse_len <= (sys_rst || !reset_pin_oe) ? 0 : pulse_len + 1;
    power_on_a: assert property ($past(sys_rst) |-> core_reset)
        else $error("no reset after start");
    fail_fast_a: assert property (
        supply_fail_detect && clk_en |=> monitor_reset && core_reset)
        else $error("slow fail reset");
    fan_out_a: assert property (
        {memory_reset, periph_reset} == {2{core_reset}})
        else $error("resets differ");
    mon_core_a: assert property (monitor_reset |-> core_reset)
        else $error("monitor reset lost");
    array_src_a: assert property (
        counter_array_watchdog_expire && clk_en |=> core_reset)
        else $error("array request lost");
    pin_hold_a: assert property (
        (reset_pin_in && !reset_pin_oe)[*4] |=> core_reset)
        else $error("pin request lost");
    wdog_start_a: assert property (
        hardware_watchdog_expire && !reset_pin_oe |-> ##[1:2] reset_pin_oe)
        else $error("no pulse");
    pulse_len_a: assert property (
        $fell(reset_pin_oe) && !$past(sys_rst) |-> pulse_len == PULSE_PERIODS)
        else $error("bad pulse length");
endmodule // pmrc_top_props
`default_nettype wire

/* File: tb/pmrc_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module pmrc_top_tb;
    logic clock = 1'b0, sys_rst = 1'b1, fail = 1'b0, osc_run = 1'b0;
    logic hw_exp = 1'b0, ca_exp = 1'b0, ext = 1'b0;
    wire osc, pin, p_out, p_oe, core, mem, per, mon;
    int mismatches = 0, check_count = 0, cycles = 0, n;
    always #5 clock = ~clock;
    pmrc_top #(.STARTUP_PERIODS(8), .PULSE_PERIODS(4)) i_pmrc_top (
        .clock, .sys_rst, .clk_en(1'b1), .supply_fail_detect(fail),
        .oscillator_input(osc), .hardware_watchdog_expire(hw_exp),
        .counter_array_watchdog_expire(ca_exp), .reset_pin_in(pin),
        .reset_pin_out(p_out), .reset_pin_oe(p_oe), .core_reset(core),
        .memory_reset(mem), .periph_reset(per), .monitor_reset(mon));
    pmrc_board i_pmrc_board (.clock, .osc_run, .ext_hold(ext),
        .pin_out(p_out), .pin_oe(p_oe), .osc, .pin);
    task automatic check(input logic [7:0] got, exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_sim;
        end
    end
    task automatic wait_free;
        n = 0;
        while (core !== 1'b0 && n < 200) begin
            @(negedge clock);
            n++;
        end
        check({core, mem, per, mon}, 8'h0);
    endtask
    task automatic held(input int k);
        repeat (k) begin
            @(negedge clock);
            check(core, 8'h1);
        end
    endtask
    task automatic t_startup;
        held(30);
        osc_run = 1'b1;
        wait_free;
        check(n >= 8, 8'h1);
    endtask
    task automatic t_fail;
        fail = 1'b1;
        @(negedge clock);
        fail = 1'b0;
        check({core, mon}, 8'h3);
        wait_free;
        check(n >= 8, 8'h1);
    endtask
    task automatic t_wdog;
        hw_exp = 1'b1;
        @(negedge clock);
        hw_exp = 1'b0;
        if (p_out !== 1'b1) @(negedge clock);
        n = 0;
        while (p_out === 1'b1 && n < 50) begin
            check(core, 8'h1);
            @(negedge clock);
            n++;
        end
        check(n, 8'h4);
        wait_free;
    endtask
    task automatic t_array;
        ca_exp = 1'b1;
        held(20);
        ca_exp = 1'b0;
        wait_free;
    endtask
    task automatic t_pin;
        ext = 1'b1;
        repeat (3) @(negedge clock);
        held(20);
        ext = 1'b0;
        wait_free;
    endtask
    task automatic t_reset;
        sys_rst = 1'b1;
        held(2);
        sys_rst = 1'b0;
        wait_free;
    endtask
    initial begin
        held(12);
        sys_rst = 1'b0;
        t_startup;
        t_fail;
        t_wdog;
        t_array;
        t_pin;
        t_reset;
        end_sim;
    end
endmodule // pmrc_top_tb
bind pmrc_top pmrc_top_props #(.PULSE_PERIODS(PULSE_PERIODS))
    i_pmrc_top_props (.*);
`default_nettype wire
